// ---- core/sspc_pkg.sv ----
// shared constants of the stepper stall and channel pwm block
package sspc_pkg;

	////////////////////////////////////////////////////////////////////
	// clock
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_PERIOD_NS = 25;

	////////////////////////////////////////////////////////////////////
	// register map, byte addresses of aligned 32-bit words
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CH_OFF = 8'h00;
	localparam logic [7:0] OFS_PWM_EN = 8'h04;
	localparam logic [7:0] OFS_ADAPT_EN = 8'h08;
	localparam logic [7:0] OFS_CFG = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_VBAT = 8'h14;

	// field positions inside the config word
	localparam int CFG_LOG_POS = 0;
	localparam int CFG_STOP_POS = 4;
	localparam int CFG_DUTY_A_POS = 8;
	localparam int CFG_DUTY_B_POS = 16;
	localparam int CFG_DUTY_C_POS = 24;

	// field positions inside the status word
	localparam int ST_ATT_POS = 0;
	localparam int ST_WARN_POS = 4;
	localparam int ST_CONF_POS = 8;
	localparam int ST_UNST_POS = 12;

	// reset values and the full duty code
	localparam logic [11:0] CH_OFF_RST = 12'hfff;
	localparam logic [4:0] DUTY_RST = 5'h00;
	localparam logic [4:0] DUTY_FULL = 5'h1f;

	////////////////////////////////////////////////////////////////////
	// step rate supervisor
	localparam int STEP_RATE_MIN_SPS = 100;
	localparam int STEP_RATE_MAX_SPS = 400;
	localparam int STEP_PER_MAX_NS = 1_000_000_000 / STEP_RATE_MIN_SPS;
	localparam int STEP_PER_MIN_NS = 1_000_000_000 / STEP_RATE_MAX_SPS;
	// longest period rounds down, shortest rounds up
	localparam int STEP_PER_MAX_CYC = STEP_PER_MAX_NS / CLK_PERIOD_NS;
	localparam int STEP_PER_MIN_CYC =
		(STEP_PER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PER_W = 19;
	localparam int STEP_DEV_PCT = 3;
	localparam int STABLE_RUN = 32;

	////////////////////////////////////////////////////////////////////
	// pwm timing
	localparam int LIN_STEP_CYC = 40;
	localparam int LOG_PWM_HZ = 245;
	localparam int LOG_PERIOD_CYC = CLK_HZ / LOG_PWM_HZ;
	localparam int LOG_STEPS = 1024;
	localparam int ADAPT_PWM_HZ = 25_000;
	localparam int ADAPT_PERIOD_CYC = CLK_HZ / ADAPT_PWM_HZ;
	localparam int ADAPT_TARGET_MV = 11_000;
	localparam int ADAPT_LIMIT = ADAPT_PERIOD_CYC * ADAPT_TARGET_MV;

	// logarithmic on-length per code, out of LOG_STEPS
	localparam logic [10:0] LOG_TBL [32] = '{
		11'h001, 11'h002, 11'h003, 11'h004, 11'h005, 11'h006, 11'h007,
		11'h008, 11'h00a, 11'h00c, 11'h00f, 11'h012, 11'h016, 11'h01b,
		11'h021, 11'h028, 11'h031, 11'h03c, 11'h04a, 11'h05a, 11'h06e,
		11'h087, 11'h0a5, 11'h0ca, 11'h0f7, 11'h12f, 11'h172, 11'h1c5,
		11'h22b, 11'h2a7, 11'h33f, 11'h400};

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- core/sspc_core.sv ----
// Behaviour
// - each motor has warning and confirmed stall flags
// - attention flag ORs all stall flags, always returned
// - attention stays set until status read clears it
// - stop bit zero leaves drivers untouched on stall
// - stall flags clear themselves when condition disappears
// - stop bit one switches off stalled motor channels
// - unstable step rate disables stall detection, restores outputs
// - one stop bit per motor group, zero if unused
// - 32 steady commutations clear unstable flag, else set
// - stable means under 3% deviation, 100-400 steps/s
// - channel index modulo three picks pwm source
// - eight-channel build drops channels 8-11 and logic
// - linear mode: three sources, shared rate, own duty
// - linear code zero near 3%, all ones fully on
// - adapted pwm overrides other settings, common 25kHz
// - adapted duty from battery voltage, about 11V effective
// - off bit, adapted enable decode off, on, hold
// - log mode 245Hz, 32 log duty steps
// - stall logic only present in stall-capable builds
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module sspc_core
	import sspc_pkg::*;
#(
	parameter int NUM_CH = 12,
	parameter bit STALL_EN = 1'b1,
	parameter int PER_MIN_CYC = STEP_PER_MIN_CYC,
	parameter int PER_MAX_CYC = STEP_PER_MAX_CYC,
	parameter int LOG_PERIOD = LOG_PERIOD_CYC,
	parameter int LIN_STEP = LIN_STEP_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic [NUM_CH/4-1:0] stall_warn_raw,
	input wire logic [NUM_CH/4-1:0] stall_conf_raw,
	input wire logic [NUM_CH-1:0] overtemp,
	input wire logic [15:0] vbat_mv,
	output logic [NUM_CH-1:0] gate_on
);

	localparam int NUM_MOT = NUM_CH / 4;
	// log prescale, never below one cycle
	localparam int LOG_TICK =
		(LOG_PERIOD / LOG_STEPS < 1) ? 1 : LOG_PERIOD / LOG_STEPS;

	////////////////////////////////////////////////////////////////////
	// whole state of the block
	typedef struct packed {
		logic [NUM_CH-1:0] ch_off, pwm_en, adapt_en, gate, ot_s1, ot_s2;
		logic log_sel, attention_summary_flag, src_adapt;
		logic [2:0] src_lin, src_log;
		logic [2:0][4:0] duty;
		logic [NUM_MOT-1:0] stop, unstable, have_prev, warn, conf;
		logic [NUM_MOT-1:0] stw_s1, stw_s2, ste_s1, ste_s2;
		logic [NUM_MOT-1:0][PER_W-1:0] per_cnt, per_prev;
		logic [NUM_MOT-1:0][5:0] run;
		logic [NUM_MOT-1:0][3:0] last_pat;
		logic [7:0] lin_pre;
		logic [4:0] lin_pos;
		logic [15:0] log_pre;
		logic [9:0] log_pos;
		logic [10:0] ad_cnt;
		logic [15:0] vbat_lat;
		logic aw_got, w_got, awready, wready, bvalid, arready, rvalid;
		logic [ADDR_W-1:0] aw_addr;
		logic [31:0] w_data, rdata;
		logic [3:0] w_strb;
		logic [1:0] bresp, rresp;
	} sspc_state_t;

	sspc_state_t st_reg; // registered state
	sspc_state_t st_next; // next state
	logic [3:0] pat; // motor group pattern being examined
	logic [PER_W-1:0] per; // period just ended
	logic base; // channel drive before overrides
	logic stat_rd; // status word read this cycle
	logic [32:0] rd_w; // old word for write merge, hit on top
	logic [32:0] rd_r; // read word, hit on top
	logic [31:0] merged; // write data after strobes
	logic [NUM_CH-1:0] kill_ch; // stall shut-off per channel
	logic [NUM_CH-1:0] pull_ch; // channels meant to be steady on

	////////////////////////////////////////////////////////////////////
	// helpers

	// period deviation below the allowed percentage of the last one
	function automatic logic dev_ok(input logic [PER_W-1:0] a,
		input logic [PER_W-1:0] b);
		logic [PER_W-1:0] d;
		d = (a > b) ? a - b : b - a;
		return (26'(d) * 26'h64) < (26'(b) * 26'(STEP_DEV_PCT));
	endfunction

	// byte-lane merge of a write over the old word
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// register word at an address, top bit marks a mapped address
	function automatic logic [32:0] reg_word(input sspc_state_t s,
		input logic [ADDR_W-1:0] a);
		logic [31:0] w;
		logic hit;
		w = '0;
		hit = 1'b1;
		unique case (a)
			OFS_CH_OFF: w[NUM_CH-1:0] = s.ch_off;
			OFS_PWM_EN: w[NUM_CH-1:0] = s.pwm_en;
			OFS_ADAPT_EN: w[NUM_CH-1:0] = s.adapt_en;
			OFS_CFG: begin
				w[CFG_LOG_POS] = s.log_sel;
				w[CFG_STOP_POS +: NUM_MOT] = s.stop;
				w[CFG_DUTY_A_POS +: 5] = s.duty[0];
				w[CFG_DUTY_B_POS +: 5] = s.duty[1];
				w[CFG_DUTY_C_POS +: 5] = s.duty[2];
			end
			OFS_STATUS: begin
				w[ST_ATT_POS] = s.attention_summary_flag;
				w[ST_WARN_POS +: NUM_MOT] = s.warn;
				w[ST_CONF_POS +: NUM_MOT] = s.conf;
				w[ST_UNST_POS +: NUM_MOT] = s.unstable;
			end
			OFS_VBAT: w[15:0] = s.vbat_lat;
			default: hit = 1'b0;
		endcase
		return {hit, w};
	endfunction

	////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		st_next = st_reg;
		pat = '0;
		per = '0;
		base = 1'b0;
		stat_rd = 1'b0;
		rd_w = '0;
		rd_r = '0;
		merged = '0;
		kill_ch = '0;

		// pin-side inputs pass two flops before use
		st_next.stw_s1 = stall_warn_raw;
		st_next.stw_s2 = st_reg.stw_s1;
		st_next.ste_s1 = stall_conf_raw;
		st_next.ste_s2 = st_reg.ste_s1;
		st_next.ot_s1 = overtemp;
		st_next.ot_s2 = st_reg.ot_s1;

		if (st_reg.lin_pre == 8'(LIN_STEP - 1)) begin
			st_next.lin_pre = '0;
			st_next.lin_pos = st_reg.lin_pos + 5'h1;
		end else begin
			st_next.lin_pre = st_reg.lin_pre + 8'h1;
		end
		// log counter spans one 245 Hz period
		if (st_reg.log_pre == 16'(LOG_TICK - 1)) begin
			st_next.log_pre = '0;
			st_next.log_pos = st_reg.log_pos + 10'h1;
		end else begin
			st_next.log_pre = st_reg.log_pre + 16'h1;
		end
		// one 25 kHz counter for every adapted channel
		if (st_reg.ad_cnt == 11'(ADAPT_PERIOD_CYC - 1)) begin
			st_next.ad_cnt = '0;
			// supply sampled once a period so a period stays coherent
			st_next.vbat_lat = vbat_mv;
		end else begin
			st_next.ad_cnt = st_reg.ad_cnt + 11'h1;
		end
		for (int i = 0; i < 3; i++) begin
			// code zero gives one step of 32, all ones always
			st_next.src_lin[i] = st_reg.lin_pos <= st_reg.duty[i];
			st_next.src_log[i] =
				{1'b0, st_reg.log_pos} < LOG_TBL[st_reg.duty[i]];
		end
		// on while count times supply stays under the limit
		st_next.src_adapt = (27'(st_reg.ad_cnt) * 27'(st_reg.vbat_lat))
			< 27'(ADAPT_LIMIT);

		// step rate supervisor, one per motor group
		for (int z = 0; z < NUM_MOT; z++) begin
			// group z is channels 4z to 4z+3
			pat = st_reg.ch_off[4*z +: 4];
			per = st_reg.per_cnt[z];
			if (per <= PER_W'(PER_MAX_CYC)) begin
				st_next.per_cnt[z] = per + 19'h1;
			end else begin
				// step stream broken: too slow or stopped
				st_next.unstable[z] = 1'b1;
				st_next.run[z] = '0;
			end
			st_next.last_pat[z] = pat;
			// a pattern change is one commutation
			if (pat != st_reg.last_pat[z]) begin
				st_next.per_cnt[z] = '0;
				st_next.per_prev[z] = per;
				st_next.have_prev[z] = 1'b1;
				if (st_reg.have_prev[z] &&
					per >= PER_W'(PER_MIN_CYC) &&
					per <= PER_W'(PER_MAX_CYC) &&
					dev_ok(per, st_reg.per_prev[z])) begin
					// count steady commutations up to 32
					if (st_reg.run[z] != 6'(STABLE_RUN)) begin
						st_next.run[z] = st_reg.run[z] + 6'h1;
					end
					if (st_reg.run[z] >= 6'(STABLE_RUN - 1)) begin
						st_next.unstable[z] = 1'b0;
					end
				end else begin
					// too much variation, a period out of range or no previous step sets the flag
					st_next.run[z] = '0;
					st_next.unstable[z] = 1'b1;
				end
			end
		end

		// flags exist only in the stall build
		// warning and confirmed flags per motor
		// flags follow the detector and drop with it
		// detection off while the rate is unstable
		st_next.warn = STALL_EN ? (st_reg.stw_s2 & ~st_reg.unstable) : '0;
		st_next.conf = STALL_EN ? (st_reg.ste_s2 & ~st_reg.unstable) : '0;

		// write channel: release response, take address and data
		if (st_reg.bvalid && bready) begin
			st_next.bvalid = 1'b0;
		end
		if (awvalid && st_reg.awready) begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = awaddr;
		end
		if (wvalid && st_reg.wready) begin
			st_next.w_got = 1'b1;
			st_next.w_data = wdata;
			st_next.w_strb = wstrb;
		end
		// both halves held and no response pending: commit
		if (st_next.aw_got && st_next.w_got && !st_reg.bvalid) begin
			rd_w = reg_word(st_reg, st_next.aw_addr);
			merged = wmerge(rd_w[31:0], st_next.w_data, st_next.w_strb);
			st_next.bresp = rd_w[32] ? RESP_OKAY : RESP_SLVERR;
			st_next.bvalid = 1'b1;
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			unique case (st_next.aw_addr)
				OFS_CH_OFF: st_next.ch_off = merged[NUM_CH-1:0];
				OFS_PWM_EN: st_next.pwm_en = merged[NUM_CH-1:0];
				OFS_ADAPT_EN: st_next.adapt_en = merged[NUM_CH-1:0];
				OFS_CFG: begin
					st_next.log_sel = merged[CFG_LOG_POS];
					// a stop bit for each motor group
					st_next.stop = merged[CFG_STOP_POS +: NUM_MOT];
					st_next.duty[0] = merged[CFG_DUTY_A_POS +: 5];
					st_next.duty[1] = merged[CFG_DUTY_B_POS +: 5];
					st_next.duty[2] = merged[CFG_DUTY_C_POS +: 5];
				end
				// status and supply words ignore writes
				default: ;
			endcase
		end
		// one write in flight: each ready only while its half is not held and no response is pending
		st_next.awready = !st_next.aw_got && !st_next.bvalid;
		st_next.wready = !st_next.w_got && !st_next.bvalid;

		// read channel
		if (st_reg.rvalid && rready) begin
			st_next.rvalid = 1'b0;
			st_next.arready = 1'b1;
		end
		if (arvalid && st_reg.arready) begin
			rd_r = reg_word(st_reg, araddr);
			st_next.rdata = rd_r[32] ? rd_r[31:0] : 32'h0;
			st_next.rresp = rd_r[32] ? RESP_OKAY : RESP_SLVERR;
			st_next.rvalid = 1'b1;
			st_next.arready = 1'b0;
			stat_rd = (araddr == OFS_STATUS);
		end

		// cleared only by a status read, a new flag wins
		st_next.attention_summary_flag = (st_reg.attention_summary_flag & ~stat_rd) |
			(|(st_reg.warn | st_reg.conf));

		// channel drive
		for (int ch = 0; ch < NUM_CH; ch++) begin
			// stop bit turns a confirmed stall into shut-off
			// with stop bit clear the stall changes nothing
			kill_ch[ch] = st_reg.stop[ch/4] & st_reg.conf[ch/4];
			if (st_reg.adapt_en[ch]) begin
				base = st_reg.src_adapt;
			// source fixed by index modulo three
			end else if (st_reg.pwm_en[ch]) begin
				base = st_reg.log_sel ? st_reg.src_log[ch%3] :
					st_reg.src_lin[ch%3];
			end else begin
				// off bit clear, no pwm: steady pull-in
				base = 1'b1;
			end
			// temperature and stall shut-off win over all
			// off bit forces the channel off
			st_next.gate[ch] = base & ~st_reg.ch_off[ch] &
				~st_reg.ot_s2[ch] & ~kill_ch[ch];
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.ch_off <= CH_OFF_RST[NUM_CH-1:0];
			st_reg.duty <= {3{DUTY_RST}};
			st_reg.unstable <= '1;
			// matches the reset off pattern: no false step after reset
			st_reg.last_pat <= CH_OFF_RST[NUM_CH-1:0];
			st_reg.awready <= 1'b1;
			st_reg.wready <= 1'b1;
			st_reg.arready <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state flops
	assign awready = st_reg.awready;
	assign wready = st_reg.wready;
	assign bvalid = st_reg.bvalid;
	assign bresp = st_reg.bresp;
	assign arready = st_reg.arready;
	assign rvalid = st_reg.rvalid;
	assign rdata = st_reg.rdata;
	assign rresp = st_reg.rresp;
	assign gate_on = st_reg.gate;

	////////////////////////////////////////////////////////////////////
	// checks
	assign pull_ch = ~st_reg.ch_off & ~st_reg.adapt_en & ~st_reg.pwm_en &
		~st_reg.ot_s2 & ~kill_ch;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_att_set;
		(|(st_reg.warn | st_reg.conf)) |=> st_reg.attention_summary_flag;
	endproperty
	a_att_set: assert property (p_att_set)
		else $error("attention flag missed a stall flag");

	property p_att_hold;
		st_reg.attention_summary_flag && !stat_rd |=> st_reg.attention_summary_flag;
	endproperty
	a_att_hold: assert property (p_att_hold)
		else $error("attention flag dropped without a status read");

	property p_kill;
		(kill_ch != '0) |=> ((st_reg.gate & $past(kill_ch)) == '0);
	endproperty
	a_kill: assert property (p_kill)
		else $error("stalled motor channel still driven");

	property p_off;
		(st_reg.ch_off != '0) |=> ((st_reg.gate & $past(st_reg.ch_off)) == '0);
	endproperty
	a_off: assert property (p_off)
		else $error("channel with off bit set is driven");

	property p_pullin;
		(pull_ch != '0) |=> ((st_reg.gate & $past(pull_ch)) == $past(pull_ch));
	endproperty
	a_pullin: assert property (p_pullin)
		else $error("pull-in channel not steadily on");

	property p_ot;
		(st_reg.ot_s2 != '0) |=> ((st_reg.gate & $past(st_reg.ot_s2)) == '0);
	endproperty
	a_ot: assert property (p_ot)
		else $error("overheated channel still driven");

	property p_sup_clear;
		$fell(st_reg.unstable[0]) |-> $past(st_reg.run[0]) ==
			6'(STABLE_RUN - 1);
	endproperty
	a_sup_clear: assert property (p_sup_clear)
		else $error("unstable flag cleared before 32 steady steps");

	property p_warn_gate;
		(st_reg.unstable != '0) |=>
			(((st_reg.warn | st_reg.conf) & $past(st_reg.unstable)) == '0);
	endproperty
	a_warn_gate: assert property (p_warn_gate)
		else $error("stall flag raised while step rate unstable");

	property p_full;
		st_reg.duty[2] == DUTY_FULL |=> st_reg.src_lin[2];
	endproperty
	a_full: assert property (p_full)
		else $error("full linear code not permanently on");

	property p_adapt_full;
		st_reg.vbat_lat <= 16'(ADAPT_TARGET_MV) |=> st_reg.src_adapt;
	endproperty
	a_adapt_full: assert property (p_adapt_full)
		else $error("low supply did not give full adapted duty");

	property p_bstand;
		st_reg.bvalid && !bready |=> st_reg.bvalid && $stable(st_reg.bresp);
	endproperty
	a_bstand: assert property (p_bstand)
		else $error("write response withdrawn before taken");

endmodule

// ---- dv/sspc_host.sv ----
`timescale 1ns/1ps
// controller model: one write and one read at a time on the register bus
module sspc_host
	import sspc_pkg::*;
(
	input wire logic clk,
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic [1:0] bresp,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	output logic awvalid,
	output logic [ADDR_W-1:0] awaddr,
	output logic wvalid,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic bready,
	output logic arvalid,
	output logic [ADDR_W-1:0] araddr,
	output logic rready
);
	////////////////////////////////////////////////////////////////////
	// idle bus from time zero
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, wdata, wstrb, araddr} = '0;
	end

	////////////////////////////////////////////////////////////////////
	// write: both halves offered at once, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		forever begin
			@(posedge clk);
			// released halves turn to garbage so a late sample shows
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
			// answer taken a cycle late so the slave must hold it
			if (bvalid) begin
				bready <= 1'b1;
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////
	// read: address held until taken, data taken at the rvalid edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			// released address turns to garbage once taken
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask
endmodule

// ---- dv/sspc_core_tb.sv ----
`timescale 1ns/1ps
module sspc_core_tb;
	import sspc_pkg::*;
	// shortened counts so the run stays small
	localparam int LSTEP = 2;
	localparam int LPER = 2048;
	logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rnd;
	logic [3:0] wstrb, pat;
	logic [1:0] bresp, rresp, br;
	logic [2:0] warn_raw, conf_raw;
	logic [11:0] overtemp, gate_on, ot;
	logic [15:0] vbat;
	logic [4:0] ca;
	logic [31:0] seed = 32'hdabf;
	logic [31:0] mreg [4];
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0;
	int e;

	sspc_core #(.NUM_CH(12), .STALL_EN(1'b1), .PER_MIN_CYC(40),
		.PER_MAX_CYC(160), .LOG_PERIOD(LPER), .LIN_STEP(LSTEP)) u_sspc_core (
		.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.stall_warn_raw(warn_raw), .stall_conf_raw(conf_raw),
		.overtemp(overtemp), .vbat_mv(vbat), .gate_on(gate_on));

	sspc_host u_sspc_host (.clk(clk), .awready(awready), .wready(wready),
		.bvalid(bvalid), .bresp(bresp), .arready(arready), .rvalid(rvalid),
		.rdata(rdata), .rresp(rresp), .awvalid(awvalid), .awaddr(awaddr),
		.wvalid(wvalid), .wdata(wdata), .wstrb(wstrb), .bready(bready),
		.arvalid(arvalid), .araddr(araddr), .rready(rready));

	////////////////////////////////////////////////////////////////////
	// clock and watchdog; the whole run needs about 17000 cycles
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			mismatches++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// write and update the register model on success
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic [1:0] r;
		u_sspc_host.wr(a, d, 4'hf, r);
		chk({30'h0, r}, {30'h0, er});
		if (er == RESP_OKAY && a < OFS_STATUS) mreg[a[3:2]] = d;
	endtask
	// unmapped addresses answer with an error and zero data
	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		logic [31:0] d;
		logic [1:0] r;
		u_sspc_host.rd(a, d, r);
		chk(d, ex);
		chk({30'h0, r}, (a > OFS_VBAT) ? 32'h2 : 32'h0);
	endtask
	// count on-cycles of one channel over a window
	task automatic meas(input int ch, input int n, input int ex);
		int on;
		on = 0;
		repeat (n) begin
			@(posedge clk);
			if (gate_on[ch] === 1'b1) on++;
		end
		chk(on, ex);
	endtask
	task automatic complete_run();
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst = 1'b1;
		{warn_raw, conf_raw, overtemp, vbat} = '0;
		mreg = '{32'hfff, 32'h0, 32'h0, 32'h0};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// reset values, read-only and unmapped places
		for (int i = 0; i < 4; i++) rd(8'(i * 4), mreg[i]);
		rd(OFS_STATUS, 32'h7000);
		chk({20'h0, gate_on}, 32'h0);
		rd(8'h18, 32'h0);
		wr(8'h1c, 32'h1, RESP_SLVERR);
		wr(OFS_STATUS, 32'hffff_ffff, RESP_OKAY);
		rd(OFS_STATUS, 32'h7000);
		// byte strobes: only byte 1 of the config word lands
		u_sspc_host.wr(OFS_CFG, 32'hffff_ffff, 4'h2, br);
		chk({30'h0, br}, {30'h0, RESP_OKAY});
		mreg[3] = 32'h0000_1f00;
		rd(OFS_CFG, mreg[3]);
		$display("test registers done");

		// steady on/off decode, then overtemperature on a random channel
		wr(OFS_CH_OFF, 32'h0f0, RESP_OKAY);
		repeat (3) @(posedge clk);
		chk({20'h0, gate_on}, 32'hf0f);
		rnd = xs();
		ot = 12'h1 << (rnd % 12);
		overtemp <= ot;
		repeat (6) @(posedge clk);
		chk({20'h0, gate_on}, {20'h0, 12'hf0f & ~ot});
		overtemp <= 12'h0;
		$display("test steady done");

		// linear sources with one random code
		rnd = xs();
		ca = rnd[4:0];
		wr(OFS_CH_OFF, 32'h0, RESP_OKAY);
		wr(OFS_PWM_EN, 32'h00f, RESP_OKAY);
		wr(OFS_CFG, {8'h1f, 8'h00, 3'h0, ca, 8'h00}, RESP_OKAY);
		repeat (4) @(posedge clk);
		meas(0, 32 * LSTEP, (ca + 1) * LSTEP);
		meas(1, 32 * LSTEP, LSTEP);
		meas(2, 32 * LSTEP, 32 * LSTEP);
		meas(3, 32 * LSTEP, (ca + 1) * LSTEP);
		meas(4, 32 * LSTEP, 32 * LSTEP);
		$display("test linear done");

		// logarithmic curve, codes 10, 0 and 31
		wr(OFS_CFG, 32'h1f00_0a01, RESP_OKAY);
		repeat (4) @(posedge clk);
		meas(0, LPER, LOG_TBL[10] * (LPER / 1024));
		meas(1, LPER, LOG_TBL[0] * (LPER / 1024));
		meas(2, LPER, LPER);
		$display("test log done");

		// adapted hold overrides the log source on channel 3
		rnd = xs();
		vbat <= 16'(11001 + rnd % 20000);
		wr(OFS_ADAPT_EN, 32'h008, RESP_OKAY);
		repeat (1700) @(posedge clk);
		e = (ADAPT_LIMIT + vbat - 1) / vbat;
		meas(3, 1600, (e > 1600) ? 1600 : e);
		rd(OFS_VBAT, {16'h0, vbat});
		vbat <= 16'd9000;
		repeat (1700) @(posedge clk);
		meas(3, 1600, 1600);
		$display("test adapted done");

		// stall on motor 0 only; the other groups keep stop bit 0
		wr(OFS_ADAPT_EN, 32'h0, RESP_OKAY);
		wr(OFS_PWM_EN, 32'h0, RESP_OKAY);
		// stop-on-stall set for the stepper group
		wr(OFS_CFG, 32'h10, RESP_OKAY);
		warn_raw <= 3'h1;
		conf_raw <= 3'h1;
		// steady 80-cycle steps on channels 0..3
		for (int k = 0; k < 40; k++) begin
			while (cyc % 80 != 0) @(posedge clk);
			pat = ~(4'h1 << (k % 4));
			wr(OFS_CH_OFF, {28'h0, pat}, RESP_OKAY);
		end
		repeat (10) @(posedge clk);
		chk({20'h0, gate_on}, 32'hff0);
		rd(OFS_STATUS, 32'h6111);
		wr(OFS_CFG, 32'h0, RESP_OKAY);
		repeat (3) @(posedge clk);
		// last commanded step kept as motor position
		chk({20'h0, gate_on}, {20'h0, 8'hff, ~pat});
		wr(OFS_CFG, 32'h10, RESP_OKAY);
		repeat (3) @(posedge clk);
		chk({20'h0, gate_on}, 32'hff0);
		// stepping stops: supervisor flags unstable, flags drop
		repeat (200) @(posedge clk);
		chk({20'h0, gate_on}, {20'h0, 8'hff, ~pat});
		rd(OFS_STATUS, 32'h7001);
		rd(OFS_STATUS, 32'h7000);
		$display("test stall done");
		complete_run();
	end
endmodule
